/* File: rtl/sblp_pkg.sv */
// Constants and types of the serial boot loader port.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package sblp_pkg;
   // Protocol codes
   localparam logic [7:0] CMD_DOWNLOAD = 8'hfa;
   localparam logic [7:0] RESULT_OK = 8'h00;
   localparam logic [7:0] RESULT_FAIL = 8'h01;
   // Download target
   localparam logic [15:0] RAM_BASE = 16'h0600;
   // Pull-up control values
   localparam logic [7:0] PULLUP_WIDE = 8'hff;
   localparam logic [7:0] PULLUP_NARROW = 8'h0f;
   localparam logic [7:0] PULLUP_OFF = 8'h00;
   // Byte framing
   localparam int BYTE_BITS = 8;
   localparam logic [3:0] LAST_BIT = 4'h7;
   localparam logic [3:0] ASYNC_STOP_IDX = 4'h9;
   localparam logic [3:0] ASYNC_FRAME_BITS = 4'ha;
   // Timing counts
   localparam logic [3:0] STARTUP_CYCLES = 4'h4;
   localparam int BAUD_DIV_DEFAULT = 434;
   localparam int SYNC_RESET_ONE = 1;

   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_SIZE_LO = 8'h02,
      ST_SIZE_HI = 8'h04,
      ST_CSUM = 8'h08,
      ST_DATA = 8'h10,
      ST_ECHO = 8'h20,
      ST_RESULT = 8'h40,
      ST_RUN = 8'h80
   } sblp_state_t;
endpackage
`default_nettype wire

/* File: rtl/sblp_sync3.sv */
// Three-stage pin synchroniser; output moves when stages two and three agree.
// Assumes an asynchronous pin and one system clock.
`default_nettype none
module sblp_sync3 #(
   parameter logic RESET_VAL = 1'b1
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_arst_n,
   // Pin and clean level
   input wire logic i_pin,
   output logic o_level
);
   logic s1;
   logic s2;
   logic s3;

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s1 <= RESET_VAL;
         s2 <= RESET_VAL;
         s3 <= RESET_VAL;
      end else begin
         s1 <= i_pin;
         s2 <= s1;
         s3 <= s2;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_level <= RESET_VAL;
      end else if (s2 == s3) begin
         o_level <= s3;
      end
   end
endmodule
`default_nettype wire

/* File: rtl/sblp_top.sv */
// Serial boot loader port: strap sampling, byte transport, download engine.
// Assumes pins are asynchronous to i_sys_clk and the RAM takes one write a cycle.
`default_nettype none
module sblp_top
   import sblp_pkg::*;
#(
   parameter int BAUD_DIV = sblp_pkg::BAUD_DIV_DEFAULT,
   parameter int ADDR_W = 16
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_arst_n,
   // Straps
   input wire logic i_boot_select_strap,
   // Serial channel one pins
   input wire logic i_uart_one_clock_pin,
   input wire logic i_uart_one_receive_pin,
   output logic o_uart_one_transmit_pin,
   input wire logic i_uart_one_request_pin,
   output logic o_uart_one_request_pin,
   output logic o_uart_one_request_pin_oe_n,
   // Monitor source for async mode busy
   input wire logic i_program_check,
   // Mode status
   output logic o_config_done,
   output logic o_normal_mode,
   output logic o_loader_mode,
   output logic o_clocked_mode,
   output logic o_single_chip_mode,
   // Pull-up controls
   output logic [7:0] o_pullup_ctrl_group0,
   output logic [7:0] o_pullup_ctrl_group1,
   output logic [7:0] o_pullup_ctrl_group2,
   output logic [7:0] o_pullup_ctrl_group3,
   output logic [7:0] o_pullup_ctrl_group4,
   // RAM write port
   output logic o_ram_we,
   output logic [ADDR_W-1:0] o_ram_addr,
   output logic [7:0] o_ram_wdata,
   // Execution transfer
   output logic o_jump,
   output logic [ADDR_W-1:0] o_jump_addr
);
   import sblp_pkg::*;

   generate
      if (BAUD_DIV < 4 || BAUD_DIV > 65535) begin : g_bad_baud
         $error("BAUD_DIV must lie in 4..65535");
      end
      if (ADDR_W < 16) begin : g_bad_addr
         $error("ADDR_W must be at least 16");
      end
   endgenerate

   localparam logic [15:0] BAUD_LAST = 16'(BAUD_DIV - 1);
   localparam logic [15:0] BAUD_HALF = 16'(BAUD_DIV / 2);

   logic strap_s;
   logic sclk_s;
   logic rxd_s;
   logic busy_in_s;
   logic sclk_q;
   logic sclk_rise;
   logic sclk_fall;

   sblp_sync3 #(.RESET_VAL(1'b1)) u_sync_strap (
      .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
      .i_pin(i_boot_select_strap), .o_level(strap_s)
   );
   sblp_sync3 #(.RESET_VAL(1'b1)) u_sync_sclk (
      .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
      .i_pin(i_uart_one_clock_pin), .o_level(sclk_s)
   );
   sblp_sync3 #(.RESET_VAL(1'b1)) u_sync_rxd (
      .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
      .i_pin(i_uart_one_receive_pin), .o_level(rxd_s)
   );
   sblp_sync3 #(.RESET_VAL(1'b0)) u_sync_busy (
      .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
      .i_pin(i_uart_one_request_pin), .o_level(busy_in_s)
   );

   // Strap capture after the synchronisers have filled
   logic [3:0] start_cnt;
   logic cfg_done;
   logic loader;
   logic clocked;
   logic pullup_en;

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         start_cnt <= 4'h0;
         cfg_done <= 1'b0;
         loader <= 1'b0;
         clocked <= 1'b0;
         pullup_en <= 1'b0;
      end else if (!cfg_done) begin
         if (start_cnt == STARTUP_CYCLES) begin
            cfg_done <= 1'b1;
            loader <= !strap_s;
            clocked <= sclk_s;
            pullup_en <= busy_in_s;
         end else begin
            start_cnt <= start_cnt + 4'h1;
         end
      end
   end

   // Pull-up values once the choice is made
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_pullup_ctrl_group0 <= PULLUP_OFF;
         o_pullup_ctrl_group1 <= PULLUP_OFF;
         o_pullup_ctrl_group2 <= PULLUP_OFF;
         o_pullup_ctrl_group3 <= PULLUP_OFF;
         o_pullup_ctrl_group4 <= PULLUP_OFF;
      end else if (cfg_done && loader && pullup_en) begin
         o_pullup_ctrl_group0 <= PULLUP_WIDE;
         o_pullup_ctrl_group1 <= PULLUP_NARROW;
         o_pullup_ctrl_group2 <= PULLUP_WIDE;
         o_pullup_ctrl_group3 <= PULLUP_WIDE;
         o_pullup_ctrl_group4 <= PULLUP_NARROW;
      end
   end

   assign o_config_done = cfg_done;
   assign o_normal_mode = cfg_done && !loader;
   assign o_loader_mode = cfg_done && loader;
   assign o_clocked_mode = cfg_done && loader && clocked;

   wire mode1 = cfg_done && loader && clocked;
   wire mode2 = cfg_done && loader && !clocked;

   // Byte interface between transports and the command engine
   logic tx_go;
   logic [7:0] tx_byte;
   logic c_rx_valid;
   logic c_tx_done;
   logic a_rx_valid;
   logic a_tx_done;
   logic [7:0] c_rx_byte;
   logic [7:0] a_rx_byte;
   sblp_state_t state;
   wire rx_valid = mode1 ? c_rx_valid : (mode2 && a_rx_valid);
   wire [7:0] rx_byte = mode1 ? c_rx_byte : a_rx_byte;
   wire tx_done = mode1 ? c_tx_done : (mode2 && a_tx_done);
   wire want_rx = (state == ST_IDLE) || (state == ST_SIZE_LO) || (state == ST_SIZE_HI)
      || (state == ST_CSUM) || (state == ST_DATA);

   // Clocked transport
   logic [2:0] c_cnt;
   logic [7:0] c_rx_sh;
   logic [7:0] c_tx_sh;
   logic c_txd;
   logic c_sending;
   logic c_busy;

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sclk_q <= 1'b1;
      end else begin
         sclk_q <= sclk_s;
      end
   end
   assign sclk_rise = mode1 && sclk_s && !sclk_q;
   assign sclk_fall = mode1 && !sclk_s && sclk_q;

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         c_cnt <= 3'h0;
         c_rx_sh <= 8'h00;
         c_rx_byte <= 8'h00;
         c_rx_valid <= 1'b0;
         c_tx_done <= 1'b0;
         c_sending <= 1'b0;
      end else begin
         c_rx_valid <= 1'b0;
         c_tx_done <= 1'b0;
         if (mode1 && tx_go) begin
            c_sending <= 1'b1;
            c_cnt <= 3'h0;
         end else if (sclk_rise) begin
            c_rx_sh <= {rxd_s, c_rx_sh[7:1]};
            c_cnt <= c_cnt + 3'h1;
            if ({1'b0, c_cnt} == LAST_BIT) begin
               c_sending <= 1'b0;
               c_tx_done <= c_sending;
               c_rx_valid <= !c_sending;
               c_rx_byte <= {rxd_s, c_rx_sh[7:1]};
            end
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         c_tx_sh <= 8'hff;
         c_txd <= 1'b1;
      end else if (mode1 && tx_go) begin
         c_tx_sh <= tx_byte;
         c_txd <= tx_byte[0];
      end else if (sclk_fall && c_sending && c_cnt != 3'h0) begin
         c_tx_sh <= {1'b1, c_tx_sh[7:1]};
         c_txd <= c_tx_sh[1];
      end
   end

   // Busy: high from first rising clock edge until the engine is ready again
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         c_busy <= 1'b1;
      end else if (sclk_rise) begin
         c_busy <= 1'b1;
      end else if (mode1 && tx_go) begin
         c_busy <= 1'b0;
      end else if (mode1 && want_rx && !rx_valid && !c_sending && c_cnt == 3'h0) begin
         c_busy <= 1'b0;
      end else if (!want_rx && !c_sending) begin
         c_busy <= 1'b1;
      end
   end

   // Asynchronous receiver
   logic a_rx_act;
   logic [15:0] a_rx_tmr;
   logic [3:0] a_rx_idx;
   logic [7:0] a_rx_sh;
   wire a_rx_tick = a_rx_act && a_rx_tmr == 16'h0000;

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         a_rx_act <= 1'b0;
         a_rx_tmr <= 16'h0000;
         a_rx_idx <= 4'h0;
         a_rx_sh <= 8'h00;
         a_rx_byte <= 8'h00;
         a_rx_valid <= 1'b0;
      end else begin
         a_rx_valid <= 1'b0;
         if (!a_rx_act) begin
            if (mode2 && !rxd_s) begin
               a_rx_act <= 1'b1;
               a_rx_tmr <= BAUD_HALF;
               a_rx_idx <= 4'h0;
            end
         end else if (!a_rx_tick) begin
            a_rx_tmr <= a_rx_tmr - 16'h0001;
         end else begin
            a_rx_tmr <= BAUD_LAST;
            a_rx_idx <= a_rx_idx + 4'h1;
            if (a_rx_idx == 4'h0 && rxd_s) begin
               a_rx_act <= 1'b0; // False start
            end else if (a_rx_idx == ASYNC_STOP_IDX) begin
               a_rx_act <= 1'b0;
               a_rx_valid <= rxd_s;
               a_rx_byte <= a_rx_sh;
            end else if (a_rx_idx != 4'h0) begin
               a_rx_sh <= {rxd_s, a_rx_sh[7:1]};
            end
         end
      end
   end

   // Asynchronous transmitter
   logic a_tx_act;
   logic [15:0] a_tx_tmr;
   logic [3:0] a_tx_idx;
   logic [9:0] a_tx_sh;
   logic a_txd;

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         a_tx_act <= 1'b0;
         a_tx_tmr <= 16'h0000;
         a_tx_idx <= 4'h0;
         a_tx_sh <= 10'h3ff;
         a_txd <= 1'b1;
         a_tx_done <= 1'b0;
      end else begin
         a_tx_done <= 1'b0;
         if (mode2 && tx_go) begin
            a_tx_act <= 1'b1;
            a_tx_sh <= {1'b1, tx_byte, 1'b0};
            a_tx_tmr <= BAUD_LAST;
            a_tx_idx <= 4'h0;
            a_txd <= 1'b0;
         end else if (a_tx_act) begin
            if (a_tx_tmr != 16'h0000) begin
               a_tx_tmr <= a_tx_tmr - 16'h0001;
            end else if (a_tx_idx == ASYNC_FRAME_BITS - 4'h1) begin
               a_tx_act <= 1'b0;
               a_tx_done <= 1'b1;
               a_txd <= 1'b1;
            end else begin
               a_tx_tmr <= BAUD_LAST;
               a_tx_idx <= a_tx_idx + 4'h1;
               a_tx_sh <= {1'b1, a_tx_sh[9:1]};
               a_txd <= a_tx_sh[1];
            end
         end
      end
   end

   // Pin drive
   assign o_uart_one_transmit_pin = mode1 ? c_txd : a_txd;
   assign o_uart_one_request_pin_oe_n = !(cfg_done && loader);
   assign o_uart_one_request_pin = mode1 ? c_busy : (mode2 && i_program_check);

   // Download command engine
   logic [15:0] size;
   logic [15:0] remain;
   logic [7:0] csum_rx;
   logic [7:0] csum_acc;
   logic [ADDR_W-1:0] wr_addr;
   logic match;

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state <= ST_IDLE;
         size <= 16'h0000;
         remain <= 16'h0000;
         csum_rx <= 8'h00;
         csum_acc <= 8'h00;
         wr_addr <= ADDR_W'(RAM_BASE);
         match <= 1'b0;
         tx_go <= 1'b0;
         tx_byte <= 8'h00;
      end else begin
         tx_go <= 1'b0;
         unique case (state)
            ST_IDLE: begin
               if (rx_valid && rx_byte == CMD_DOWNLOAD) begin
                  state <= ST_SIZE_LO;
               end
            end
            ST_SIZE_LO: begin
               if (rx_valid) begin
                  size[7:0] <= rx_byte;
                  state <= ST_SIZE_HI;
               end
            end
            ST_SIZE_HI: begin
               if (rx_valid) begin
                  size[15:8] <= rx_byte;
                  state <= ST_CSUM;
               end
            end
            ST_CSUM: begin
               if (rx_valid) begin
                  csum_rx <= rx_byte;
                  csum_acc <= 8'h00;
                  remain <= size;
                  wr_addr <= ADDR_W'(RAM_BASE);
                  if (size == 16'h0000) begin
                     match <= (rx_byte == 8'h00);
                     state <= ST_ECHO;
                     tx_go <= 1'b1;
                     tx_byte <= CMD_DOWNLOAD;
                  end else begin
                     state <= ST_DATA;
                  end
               end
            end
            ST_DATA: begin
               if (rx_valid) begin
                  csum_acc <= csum_acc + rx_byte;
                  wr_addr <= wr_addr + ADDR_W'(1);
                  remain <= remain - 16'h0001;
                  if (remain == 16'h0001) begin
                     match <= (8'(csum_acc + rx_byte) == csum_rx);
                     state <= ST_ECHO;
                     tx_go <= 1'b1;
                     tx_byte <= CMD_DOWNLOAD;
                  end
               end
            end
            ST_ECHO: begin
               if (tx_done) begin
                  state <= ST_RESULT;
                  tx_go <= 1'b1;
                  tx_byte <= match ? RESULT_OK : RESULT_FAIL;
               end
            end
            ST_RESULT: begin
               if (tx_done) begin
                  state <= match ? ST_RUN : ST_IDLE;
               end
            end
            ST_RUN: begin
               state <= ST_RUN;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // RAM writes
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_ram_we <= 1'b0;
         o_ram_addr <= '0;
         o_ram_wdata <= 8'h00;
      end else begin
         o_ram_we <= (state == ST_DATA) && rx_valid;
         if ((state == ST_DATA) && rx_valid) begin
            o_ram_addr <= wr_addr;
            o_ram_wdata <= rx_byte;
         end
      end
   end

   // Execution hand-off
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_jump <= 1'b0;
         o_jump_addr <= '0;
         o_single_chip_mode <= 1'b0;
      end else begin
         o_jump <= (state == ST_RESULT) && tx_done && match;
         if ((state == ST_RESULT) && tx_done && match) begin
            o_jump_addr <= ADDR_W'(RAM_BASE);
            o_single_chip_mode <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

/* File: tb/sblp_prog.sv */
// Serial programmer model: clocked and asynchronous byte transfers.
// Assumes the bench clock; tasks are called by the bench.
`default_nettype none
module sblp_prog #(
   parameter int BD = 8
) (
   // Clock and mode
   input wire logic i_clk,
   input wire logic i_async,
   // Device lines
   input wire logic i_busy,
   input wire logic i_txd,
   output wire logic o_sclk,
   output logic o_rxd
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sck;

   initial begin
      sck = 1'b1;
      o_rxd = 1'b1;
   end
   // Clock pin stands high between frames, low as async strap
   assign o_sclk = i_async ? 1'b0 : sck;

   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      int n;
      n = 0;
      while (i_busy !== 1'b0 && n < 400) begin
         @(posedge i_clk);
         n++;
      end
      for (int i = 0; i < 8; i++) begin
         @(posedge i_clk);
         sck <= 1'b0;
         o_rxd <= tx[i];
         repeat (4) @(posedge i_clk);
         sck <= 1'b1;
         repeat (3) @(posedge i_clk);
         rx[i] = i_txd;
      end
      @(posedge i_clk);
      o_rxd <= ~tx[7];
      repeat (4) @(posedge i_clk);
      // Receive line back to idle mark so a later async start is clean
      o_rxd <= 1'b1;
   endtask

   task automatic aput(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         o_rxd <= f[i];
         repeat (BD) @(posedge i_clk);
      end
   endtask

   task automatic aget(output logic [7:0] b);
      int n;
      n = 0;
      while (i_txd !== 1'b0 && n < 3000) begin
         @(posedge i_clk);
         n++;
      end
      repeat (BD / 2) @(posedge i_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BD) @(posedge i_clk);
         b[i] = i_txd;
      end
   endtask
endmodule
`default_nettype wire

/* File: tb/sblp_sva.sv */
// Checker for the boot loader port, watching only the top ports.
// Assumes one clock domain; bound to every sblp_top below.
`default_nettype none
module sblp_sva
   import sblp_pkg::*;
#(
   parameter int ADDR_W = 16
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_arst_n,
   // Pins
   input wire logic i_boot_select_strap,
   input wire logic i_uart_one_clock_pin,
   input wire logic i_uart_one_request_pin,
   input wire logic i_program_check,
   input wire logic o_uart_one_transmit_pin,
   input wire logic o_uart_one_request_pin,
   input wire logic o_uart_one_request_pin_oe_n,
   // Status and pull-ups
   input wire logic o_config_done,
   input wire logic o_normal_mode,
   input wire logic o_loader_mode,
   input wire logic o_clocked_mode,
   input wire logic o_single_chip_mode,
   input wire logic [7:0] o_pullup_ctrl_group0,
   input wire logic [7:0] o_pullup_ctrl_group1,
   input wire logic [7:0] o_pullup_ctrl_group2,
   input wire logic [7:0] o_pullup_ctrl_group3,
   input wire logic [7:0] o_pullup_ctrl_group4,
   // RAM and jump
   input wire logic o_ram_we,
   input wire logic [ADDR_W-1:0] o_ram_addr,
   input wire logic o_jump,
   input wire logic [ADDR_W-1:0] o_jump_addr
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_arst_n);

   AST_BOOT_MODE: assert property ($rose(o_config_done) |->
      o_normal_mode == i_boot_select_strap && o_loader_mode == !i_boot_select_strap)
      else $error("Boot mode differs from strap");
   AST_LINK_MODE: assert property ($rose(o_config_done) && o_loader_mode |->
      o_clocked_mode == i_uart_one_clock_pin)
      else $error("Link mode differs from clock pin");
   AST_PULLUP_SEL: assert property ($rose(o_config_done) |-> ##1
      (o_pullup_ctrl_group0 == 8'hff) == (o_loader_mode && $past(i_uart_one_request_pin, 2)))
      else $error("Pull-up choice differs from busy pin");
   AST_PULLUP_SET: assert property (o_pullup_ctrl_group0 != 8'h00 |-> o_loader_mode &&
      {o_pullup_ctrl_group1, o_pullup_ctrl_group2, o_pullup_ctrl_group3,
      o_pullup_ctrl_group4} == 32'h0fffff0f)
      else $error("Pull-up values wrong");
   AST_PIN_IN: assert property (!o_config_done |->
      o_uart_one_request_pin_oe_n && o_uart_one_transmit_pin)
      else $error("Busy pin driven before selection");
   AST_PIN_OUT: assert property (o_config_done && $past(o_config_done) && o_loader_mode |->
      !o_uart_one_request_pin_oe_n)
      else $error("Busy pin not driven in loader mode");
   AST_MONITOR: assert property (o_config_done && o_loader_mode && !o_clocked_mode |->
      o_uart_one_request_pin == i_program_check)
      else $error("Busy pin not showing monitor");
   AST_BUSY_RISE: assert property (o_loader_mode && o_clocked_mode &&
      !o_uart_one_request_pin && $rose(i_uart_one_clock_pin) |-> ##[1:8] o_uart_one_request_pin)
      else $error("Busy did not rise on reception");
   AST_RAM_ADDR: assert property (o_ram_we |->
      o_ram_addr >= ADDR_W'(16'h0600) && !o_single_chip_mode)
      else $error("RAM write outside download area");
   AST_JUMP: assert property (o_jump |-> o_jump_addr == ADDR_W'(16'h0600)
      ##1 !o_jump && o_single_chip_mode)
      else $error("Jump target or mode wrong");
   AST_NORMAL_IDLE: assert property (o_normal_mode |->
      !o_ram_we && !o_jump && o_pullup_ctrl_group0 == 8'h00)
      else $error("Loader activity in normal mode");

   cover property (o_jump);
   cover property (o_ram_we);
   cover property ($rose(o_config_done) && o_loader_mode && !o_clocked_mode);
   cover property (o_pullup_ctrl_group0 == 8'hff);
endmodule

bind sblp_top sblp_sva #(.ADDR_W(ADDR_W)) u_sva (
   .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_boot_select_strap(i_boot_select_strap),
   .i_uart_one_clock_pin(i_uart_one_clock_pin), .i_program_check(i_program_check),
   .i_uart_one_request_pin(i_uart_one_request_pin),
   .o_uart_one_transmit_pin(o_uart_one_transmit_pin),
   .o_uart_one_request_pin(o_uart_one_request_pin),
   .o_uart_one_request_pin_oe_n(o_uart_one_request_pin_oe_n),
   .o_config_done(o_config_done), .o_normal_mode(o_normal_mode),
   .o_loader_mode(o_loader_mode), .o_clocked_mode(o_clocked_mode),
   .o_single_chip_mode(o_single_chip_mode), .o_pullup_ctrl_group0(o_pullup_ctrl_group0),
   .o_pullup_ctrl_group1(o_pullup_ctrl_group1), .o_pullup_ctrl_group2(o_pullup_ctrl_group2),
   .o_pullup_ctrl_group3(o_pullup_ctrl_group3), .o_pullup_ctrl_group4(o_pullup_ctrl_group4),
   .o_ram_we(o_ram_we), .o_ram_addr(o_ram_addr), .o_jump(o_jump), .o_jump_addr(o_jump_addr)
);
`default_nettype wire

/* File: tb/sblp_tb_top.sv */
// Bench for the boot loader port: straps, both links, download frames.
// Assumes sblp_prog as far side and the bound checker.
`default_nettype none
module sblp_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import sblp_pkg::*;
   localparam int BD = 8;
   localparam int LIMIT = 20000;
   logic clk = 1'b0;
   logic rst_n, strap, asy, bstrap, pchk;
   logic sclk, rxd, txd, busy_o, oe_n, busy_w, cfg, nrm, ldr, clkm, sc, we, jmp;
   logic [7:0] pu0, pu1, pu2, pu3, pu4, rd;
   logic [15:0] ra, ja;
   logic [15:0] wa[$];
   logic [7:0] wd[$];
   int njmp, failures, tests_run, cyc;

   always #10 clk = ~clk;
   // Busy pin: board strap level unless the device drives it
   assign busy_w = oe_n ? bstrap : busy_o;

   sblp_top #(.BAUD_DIV(BD), .ADDR_W(16)) uut (
      .i_sys_clk(clk), .i_arst_n(rst_n), .i_boot_select_strap(strap),
      .i_uart_one_clock_pin(sclk), .i_uart_one_receive_pin(rxd),
      .o_uart_one_transmit_pin(txd), .i_uart_one_request_pin(busy_w),
      .o_uart_one_request_pin(busy_o), .o_uart_one_request_pin_oe_n(oe_n),
      .i_program_check(pchk), .o_config_done(cfg), .o_normal_mode(nrm),
      .o_loader_mode(ldr), .o_clocked_mode(clkm), .o_single_chip_mode(sc),
      .o_pullup_ctrl_group0(pu0), .o_pullup_ctrl_group1(pu1),
      .o_pullup_ctrl_group2(pu2), .o_pullup_ctrl_group3(pu3),
      .o_pullup_ctrl_group4(pu4), .o_ram_we(we), .o_ram_addr(ra),
      .o_ram_wdata(rd), .o_jump(jmp), .o_jump_addr(ja)
   );
   sblp_prog #(.BD(BD)) p (
      .i_clk(clk), .i_async(asy), .i_busy(busy_w), .i_txd(txd), .o_sclk(sclk), .o_rxd(rxd)
   );

   always @(posedge clk) begin
      if (we) begin
         wa.push_back(ra);
         wd.push_back(rd);
      end
      if (jmp) njmp++;
      cyc++;
      if (cyc == LIMIT) begin
         failures++;
         test_done();
      end
   end

   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic rst(input logic bs, input logic a, input logic bp);
      rst_n <= 1'b0;
      strap <= bs;
      asy <= a;
      bstrap <= bp;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (12) @(posedge clk);
      wa.delete();
      wd.delete();
      njmp = 0;
   endtask

   task automatic frame(input logic [7:0] f[$]);
      logic [7:0] r;
      foreach (f[i]) begin
         if (asy) p.aput(f[i]);
         else p.xfer(f[i], r);
      end
   endtask

   task automatic reply(input logic [7:0] res);
      logic [7:0] r;
      for (int i = 0; i < 2; i++) begin
         if (asy) p.aget(r);
         else p.xfer(8'hff, r);
         chk("reply", 40'(i == 0 ? 8'hfa : res), 40'(r));
      end
   endtask

   task automatic ram_chk(input logic [7:0] d[$]);
      chk("ram count", 40'(d.size()), 40'(wa.size()));
      foreach (d[i]) begin
         chk("ram addr", 40'(16'h0600 + i), 40'(wa[i]));
         chk("ram data", 40'(d[i]), 40'(wd[i]));
      end
   endtask

   task automatic jump_chk(input int n);
      repeat (20) @(posedge clk);
      chk("jumps", 40'(n), 40'(njmp));
      chk("single chip", 40'(n), 40'(sc));
      if (n > 0) chk("jump addr", 40'h600, 40'(ja));
   endtask

   task automatic t_normal();
      rst(1'b1, 1'b0, 1'b1);
      chk("config", 40'h1, 40'(cfg));
      chk("normal", 40'h1, 40'(nrm));
      chk("loader", 40'h0, 40'(ldr));
      chk("oe_n", 40'h1, 40'(oe_n));
      chk("pullups", 40'h0, {pu0, pu1, pu2, pu3, pu4});
      $display("test normal done");
   endtask

   task automatic t_clk_good();
      rst(1'b0, 1'b0, 1'b1);
      chk("clocked", 40'h1, 40'(clkm));
      chk("oe_n", 40'h0, 40'(oe_n));
      chk("busy", 40'h0, 40'(busy_o));
      chk("pullups", 40'hff0fffff0f, {pu0, pu1, pu2, pu3, pu4});
      frame('{8'hfa, 8'h02, 8'h00, 8'h46, 8'h12, 8'h34});
      reply(RESULT_OK);
      ram_chk('{8'h12, 8'h34});
      jump_chk(1);
      chk("pullups kept", 40'hff0fffff0f, {pu0, pu1, pu2, pu3, pu4});
      $display("test clocked download done");
   endtask

   task automatic t_clk_bad();
      rst(1'b0, 1'b0, 1'b0);
      chk("pullups", 40'h0, {pu0, pu1, pu2, pu3, pu4});
      frame('{8'h55, 8'hfa, 8'h01, 8'h00, 8'h00, 8'h77});
      reply(RESULT_FAIL);
      jump_chk(0);
      frame('{8'hfa, 8'h00, 8'h00, 8'h00});
      reply(RESULT_OK);
      ram_chk('{8'h77});
      jump_chk(1);
      $display("test checksum mismatch done");
   endtask

   task automatic t_async();
      rst(1'b0, 1'b1, 1'b1);
      chk("clocked", 40'h0, 40'(clkm));
      pchk <= 1'b1;
      repeat (2) @(posedge clk);
      chk("monitor", 40'h1, 40'(busy_o));
      pchk <= 1'b0;
      repeat (2) @(posedge clk);
      chk("monitor", 40'h0, 40'(busy_o));
      frame('{8'hfa, 8'h03, 8'h00, 8'h80, 8'h01, 8'h80, 8'hff});
      reply(RESULT_OK);
      ram_chk('{8'h01, 8'h80, 8'hff});
      jump_chk(1);
      $display("test async download done");
   endtask

   initial begin
      rst_n = 1'b0;
      strap = 1'b1;
      asy = 1'b0;
      bstrap = 1'b1;
      pchk = 1'b0;
      repeat (5) @(posedge clk);
      t_normal();
      t_clk_good();
      t_clk_bad();
      t_async();
      test_done();
   end
endmodule
`default_nettype wire
